/* hdl/dms_defines.vh */
/*
  Shared constants for the margin and slew control block: command codes,
  register field positions, reset values, operation codes and timing.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DMS_DEFINES_VH
`define DMS_DEFINES_VH

// Command codes (register addresses on the two-wire bus)
`define DMS_CMD_OPERATION     8'h01
`define DMS_CMD_DAC_DATA      8'h21
`define DMS_CMD_MARGIN_HIGH   8'h25
`define DMS_CMD_MARGIN_LOW    8'h26
`define DMS_CMD_BUS_STATUS    8'h78
`define DMS_CMD_BUS_REVISION  8'h98
`define DMS_CMD_GEN_CONFIG    8'hD1
`define DMS_CMD_SECOND_CONFIG 8'hD2
`define DMS_CMD_TRIGGER       8'hD3

// Field positions
`define DMS_CODE_MSB          11
`define DMS_CODE_LSB          2
`define DMS_FAULT_BIT         9
`define DMS_MAP_MARGIN_BIT    12
`define DMS_GPI_EN_BIT        3
`define DMS_NVM_PROG_BIT      4
`define DMS_SLEW_MSB          3
`define DMS_SLEW_LSB          0
`define DMS_OP_MSB            15
`define DMS_OP_LSB            8

// Field values
`define DMS_SLEW_NONE         4'h0
`define DMS_SLEW_4P9MS        4'h4
`define DMS_CODE_STEP         10'h001
`define DMS_OP_OFF            8'h00
`define DMS_OP_ON             8'h80
`define DMS_OP_MARGIN_HIGH    8'hA4
`define DMS_OP_MARGIN_LOW     8'h94

// Reset values
`define DMS_RST_WORD          16'h0000
`define DMS_RST_CODE          10'h000

// Timing
`define DMS_MCLK_MHZ          40
`define DMS_SLEW_INTERVAL_NS  4915200

`endif

/* hdl/dms_sync.v */
/*
  Two-flop synchroniser bank, one pair of flops per bit.
  Assumes inputs are asynchronous to clk_i; RST_VAL gives idle levels.
*/
`timescale 1ns/1ps
`default_nettype none

module dms_sync #(
  parameter       W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         nrst_i,
  // Data
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      reg meta;
      reg stable;
      always @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          meta   <= RST_VAL[g];
          stable <= RST_VAL[g];
        end
        else
        begin
          meta   <= d_i[g];
          stable <= meta;
        end
      end
      assign q_o[g] = stable;
    end
  endgenerate

endmodule // dms_sync

`default_nettype wire

/* hdl/dms_margin_slew.v */
/*
  Margin and slew control for a single-channel converter: two-wire bus
  register slave, general input pin edges, ramp generator, fault status.
  Assumes bus and pin are asynchronous and far slower than mclk_i.
*/
// Function
// (R1) A write with a wrong clock count, a read before any write, an invalid command or unsupported data sets the fault flag at status bit 9.
// (R2) The fault flag stays set until the host writes 1 to that bit, which clears it.
// (R3) Writing 0 to the fault flag, or anything to the other status bits, changes nothing.
// (R4) With the pin mapped to margin control, a rising edge ramps the output toward the upper margin code.
// (R5) With the pin mapped to margin control, a falling edge ramps the output toward the lower margin code.
// (R6) A pin change during a ramp reverses the direction only after the running step interval ends.
// (R7) Ramp time equals the code difference times the step size times the step interval.
// (R8) A one-code step and a 4.9152 ms step interval are selected through the general configuration register.
// (R9) The host writes 10-bit codes left aligned to 12 bits, in bits 11 to 2 of the word.
// (R10) A register write carries the command code, then the high data byte, then the low data byte.
// (R11) Writing 0x1000 to the second configuration register (0xD2) maps the pin to margin control.
// (R12) Writing 0x0408 to the trigger register (0xD3) enables the pin so its edges act.
// (R13) Writing 0x0418 to the trigger register starts nonvolatile programming and keeps the pin enabled.
// (R14) Operation codes 00h off, 80h on, A4h to upper margin, 94h to lower margin.
// (R15) Level codes are unsigned straight binary in bits 11 down to 2.
`timescale 1ns/1ps
`default_nettype none
`include "dms_defines.vh"

module dms_margin_slew #(
  parameter [6:0] DEV_ADDR    = 7'h48,   // Arbitrary bus address
  parameter [7:0] REVISION    = 8'h5A,   // Arbitrary revision code
  parameter       TW          = 18,
  parameter       SLEW_CYCLES = `DMS_SLEW_INTERVAL_NS * `DMS_MCLK_MHZ / 1000
) (
  // Clock and reset
  input  wire       mclk_i,
  input  wire       nrst_i,
  // Two-wire bus, open drain
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  // General input pin
  input  wire       general_input_pin_i,
  // Converter side
  output reg  [9:0] dac_code_o,
  output reg        dac_en_o,
  output reg        ramping_o,
  output reg        nvm_prog_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACKA = 3'h2;
  localparam [2:0] ST_WRX  = 3'h3;
  localparam [2:0] ST_ACKW = 3'h4;
  localparam [2:0] ST_RDX  = 3'h5;
  localparam [2:0] ST_ACKR = 3'h6;
  localparam [TW-1:0] SLEW_LAST = SLEW_CYCLES[TW-1:0] - {{(TW-1){1'b0}}, 1'b1};

  wire [2:0] s_in;
  dms_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
    .clk_i  (mclk_i),
    .nrst_i (nrst_i),
    .d_i    ({general_input_pin_i, sda_i, scl_i}),
    .q_o    (s_in)
  );

  reg        p_scl;
  reg        p_sda;
  reg        p_gpi;
  wire       s_scl    = s_in[0];
  wire       s_sda    = s_in[1];
  wire       s_gpi    = s_in[2];
  wire       scl_rise = s_scl & ~p_scl;
  wire       scl_fall = ~s_scl & p_scl;
  wire       bus_start = s_scl & p_scl & p_sda & ~s_sda;
  wire       bus_stop  = s_scl & p_scl & ~p_sda & s_sda;

  reg  [2:0] state;
  reg  [2:0] bit_cnt;
  reg  [7:0] shreg;
  reg  [7:0] tx;
  reg        got;
  reg        rw;
  reg        wr_act;
  reg  [2:0] nbytes;
  reg        rd_lsb;
  reg        ptr_valid;
  reg  [7:0] cmd;
  reg  [7:0] msb;

  // Registers
  reg [15:0] dac_data;
  reg [15:0] margin_high;
  reg [15:0] margin_low;
  reg [15:0] operation;
  reg [15:0] gen_config;
  reg [15:0] second_configuration;
  reg [15:0] trigger;
  reg        comm_fault_flag;
  reg  [9:0] target;
  reg [TW-1:0] timer;

  wire [7:0] full_byte = {shreg[6:0], s_sda};
  wire       byte_in   = scl_rise & (bit_cnt == 3'h7) & (state == ST_ADDR || state == ST_WRX);
  wire       data_byte = byte_in & (state == ST_WRX);
  wire       commit    = data_byte & (nbytes == 3'h2);
  wire [15:0] wdata    = {msb, full_byte};
  wire       seg_end   = (bus_stop | bus_start) & wr_act;

  reg        cmd_known;
  always @*
  begin
    case (full_byte)
      `DMS_CMD_OPERATION, `DMS_CMD_DAC_DATA, `DMS_CMD_MARGIN_HIGH, `DMS_CMD_MARGIN_LOW,
      `DMS_CMD_BUS_STATUS, `DMS_CMD_BUS_REVISION, `DMS_CMD_GEN_CONFIG,
      `DMS_CMD_SECOND_CONFIG, `DMS_CMD_TRIGGER: cmd_known = 1'b1;
      default:                                  cmd_known = 1'b0;
    endcase
  end

  reg        data_ok;
  always @*
  begin
    data_ok = 1'b1;
    case (cmd)
      `DMS_CMD_OPERATION:
        data_ok = (wdata[`DMS_OP_MSB:`DMS_OP_LSB] == `DMS_OP_OFF) ||
                  (wdata[`DMS_OP_MSB:`DMS_OP_LSB] == `DMS_OP_ON) ||
                  (wdata[`DMS_OP_MSB:`DMS_OP_LSB] == `DMS_OP_MARGIN_HIGH) ||
                  (wdata[`DMS_OP_MSB:`DMS_OP_LSB] == `DMS_OP_MARGIN_LOW);        // (R14)
      `DMS_CMD_GEN_CONFIG:
        data_ok = (wdata[`DMS_SLEW_MSB:`DMS_SLEW_LSB] == `DMS_SLEW_NONE) ||
                  (wdata[`DMS_SLEW_MSB:`DMS_SLEW_LSB] == `DMS_SLEW_4P9MS);       // (R8)
      `DMS_CMD_BUS_REVISION:
        data_ok = 1'b0;
      default:
        data_ok = 1'b1;
    endcase
  end

  reg [15:0] rd_word;
  always @*
  begin
    case (cmd)
      `DMS_CMD_OPERATION:     rd_word = operation;
      `DMS_CMD_DAC_DATA:      rd_word = dac_data;
      `DMS_CMD_MARGIN_HIGH:   rd_word = margin_high;
      `DMS_CMD_MARGIN_LOW:    rd_word = margin_low;
      `DMS_CMD_BUS_STATUS:    rd_word = {6'h00, comm_fault_flag, 9'h000};
      `DMS_CMD_BUS_REVISION:  rd_word = {REVISION, 8'h00};
      `DMS_CMD_GEN_CONFIG:    rd_word = gen_config;
      `DMS_CMD_SECOND_CONFIG: rd_word = second_configuration;
      `DMS_CMD_TRIGGER:       rd_word = trigger;
      default:                rd_word = `DMS_RST_WORD;
    endcase
  end

  // Fault sources
  wire addr_match = (full_byte[7:1] == DEV_ADDR);
  // The SCL rise ahead of a STOP or repeated START counts as one bit
  wire f_clocks   = seg_end & ((state == ST_WRX && bit_cnt != 3'h1) ||
                               (nbytes != 3'h1 && nbytes != 3'h3));              // (R1)
  wire f_rd_early = byte_in & (state == ST_ADDR) & addr_match & full_byte[0] & ~ptr_valid; // (R1)
  wire f_cmd      = data_byte & (nbytes == 3'h0) & ~cmd_known;                   // (R1)
  wire f_data     = commit & ~data_ok;                                           // (R1)
  wire fault_set  = f_clocks | f_rd_early | f_cmd | f_data;
  // Clear only on a 1 in the flag position; a new fault in the same cycle wins
  wire fault_clr  = commit & (cmd == `DMS_CMD_BUS_STATUS) & wdata[`DMS_FAULT_BIT]; // (R2) (R3)

  // Bus engine
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      p_scl     <= 1'b1;
      p_sda     <= 1'b1;
      state     <= ST_IDLE;
      bit_cnt   <= 3'h0;
      shreg     <= 8'h00;
      tx        <= 8'h00;
      got       <= 1'b0;
      rw        <= 1'b0;
      wr_act    <= 1'b0;
      nbytes    <= 3'h0;
      rd_lsb    <= 1'b0;
      ptr_valid <= 1'b0;
      cmd       <= 8'h00;
      msb       <= 8'h00;
      sda_o     <= 1'b0;
      sda_oe_o  <= 1'b0;
    end
    else
    begin
      p_scl <= s_scl;
      p_sda <= s_sda;
      if (seg_end)
        wr_act <= 1'b0;
      if (bus_start)
      begin
        state    <= ST_ADDR;
        bit_cnt  <= 3'h0;
        got      <= 1'b0;
        sda_oe_o <= 1'b0;
      end
      else if (bus_stop)
      begin
        state    <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_WRX:
          begin
            if (scl_rise)
            begin
              shreg   <= full_byte;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
                got <= 1'b1;
              if (byte_in && state == ST_ADDR)
              begin
                rw <= full_byte[0];
                if (!addr_match)
                  state <= ST_IDLE;
                else if (!full_byte[0])
                begin
                  wr_act <= 1'b1;
                  nbytes <= 3'h0;
                end
              end
              if (data_byte)
              begin
                // Command first, then high byte, then low byte
                if (nbytes == 3'h0)
                begin
                  cmd       <= full_byte;                                        // (R10)
                  ptr_valid <= 1'b1;
                end
                if (nbytes == 3'h1)
                  msb <= full_byte;                                              // (R10)
                if (nbytes != 3'h4)
                  nbytes <= nbytes + 3'h1;
              end
            end
            else if (scl_fall && got)
            begin
              got      <= 1'b0;
              sda_oe_o <= 1'b1;
              state    <= (state == ST_ADDR) ? ST_ACKA : ST_ACKW;
            end
          end
          ST_ACKA:
          begin
            if (scl_fall)
            begin
              rd_lsb <= 1'b0;
              if (rw)
              begin
                tx       <= rd_word[15:8];
                sda_oe_o <= ~rd_word[15];
                state    <= ST_RDX;
              end
              else
              begin
                sda_oe_o <= 1'b0;
                state    <= ST_WRX;
              end
            end
          end
          ST_ACKW:
          begin
            if (scl_fall)
            begin
              sda_oe_o <= 1'b0;
              state    <= ST_WRX;
            end
          end
          ST_RDX:
          begin
            if (scl_rise)
            begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
                got <= 1'b1;
            end
            else if (scl_fall)
            begin
              if (got)
              begin
                got      <= 1'b0;
                sda_oe_o <= 1'b0;
                state    <= ST_ACKR;
              end
              else
              begin
                tx       <= {tx[6:0], 1'b1};
                sda_oe_o <= ~tx[6];
              end
            end
          end
          ST_ACKR:
          begin
            if (scl_rise && s_sda)
              state <= ST_IDLE;
            else if (scl_fall)
            begin
              // The word repeats from its high byte; reads do not advance the command
              rd_lsb   <= ~rd_lsb;
              tx       <= rd_lsb ? rd_word[15:8] : rd_word[7:0];
              sda_oe_o <= rd_lsb ? ~rd_word[15] : ~rd_word[7];
              state    <= ST_RDX;
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // Register file, margin selection and ramp
  wire       gpi_live  = second_configuration[`DMS_MAP_MARGIN_BIT] & trigger[`DMS_GPI_EN_BIT]; // (R11) (R12)
  wire       gpi_rise  = gpi_live & s_gpi & ~p_gpi;
  wire       gpi_fall  = gpi_live & ~s_gpi & p_gpi;
  wire [9:0] hi_code   = margin_high[`DMS_CODE_MSB:`DMS_CODE_LSB];                // (R15)
  wire [9:0] lo_code   = margin_low[`DMS_CODE_MSB:`DMS_CODE_LSB];                 // (R15)
  wire       w_ok      = commit & data_ok;
  wire [7:0] op_new    = wdata[`DMS_OP_MSB:`DMS_OP_LSB];
  wire       slew_on   = (gen_config[`DMS_SLEW_MSB:`DMS_SLEW_LSB] == `DMS_SLEW_4P9MS); // (R8)
  wire       tick      = (timer == SLEW_LAST);
  wire [9:0] gap_up    = target - dac_code_o;
  wire [9:0] gap_dn    = dac_code_o - target;

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      p_gpi                <= 1'b1;
      dac_data             <= `DMS_RST_WORD;
      margin_high          <= `DMS_RST_WORD;
      margin_low           <= `DMS_RST_WORD;
      operation            <= `DMS_RST_WORD;
      gen_config           <= `DMS_RST_WORD;
      second_configuration <= `DMS_RST_WORD;
      trigger              <= `DMS_RST_WORD;
      comm_fault_flag      <= 1'b0;
      target               <= `DMS_RST_CODE;
      timer                <= {TW{1'b0}};
      dac_code_o           <= `DMS_RST_CODE;
      dac_en_o             <= 1'b0;
      ramping_o            <= 1'b0;
      nvm_prog_o           <= 1'b0;
    end
    else
    begin
      p_gpi           <= s_gpi;
      comm_fault_flag <= fault_set | (comm_fault_flag & ~fault_clr);             // (R1) (R2)
      nvm_prog_o      <= w_ok & (cmd == `DMS_CMD_TRIGGER) & wdata[`DMS_NVM_PROG_BIT]; // (R13)
      if (w_ok)
      begin
        case (cmd)
          `DMS_CMD_DAC_DATA:
          begin
            dac_data   <= wdata;
            target     <= wdata[`DMS_CODE_MSB:`DMS_CODE_LSB];                    // (R9) (R15)
            dac_code_o <= wdata[`DMS_CODE_MSB:`DMS_CODE_LSB];
          end
          `DMS_CMD_MARGIN_HIGH:   margin_high <= wdata;                          // (R9)
          `DMS_CMD_MARGIN_LOW:    margin_low  <= wdata;                          // (R9)
          `DMS_CMD_GEN_CONFIG:    gen_config  <= wdata;                          // (R8)
          `DMS_CMD_SECOND_CONFIG: second_configuration <= wdata;                 // (R11)
          // Programming bit is a strobe, never held
          `DMS_CMD_TRIGGER:       trigger <= wdata & ~(16'h0001 << `DMS_NVM_PROG_BIT); // (R12) (R13)
          `DMS_CMD_OPERATION:
          begin
            operation <= wdata;
            dac_en_o  <= (op_new != `DMS_OP_OFF);                                // (R14)
            if (op_new == `DMS_OP_MARGIN_HIGH)
              target <= hi_code;                                                 // (R14)
            if (op_new == `DMS_OP_MARGIN_LOW)
              target <= lo_code;                                                 // (R14)
          end
          default:
            dac_en_o <= dac_en_o;
        endcase
      end
      else if (gpi_rise)
        target <= hi_code;                                                       // (R4)
      else if (gpi_fall)
        target <= lo_code;                                                       // (R5)

      // Only the target moves on a pin edge; with slewing on the step waits for the next tick
      if (dac_code_o == target)
      begin
        timer     <= {TW{1'b0}};
        ramping_o <= 1'b0;
      end
      else if (!slew_on)
      begin
        dac_code_o <= target;
        ramping_o  <= 1'b0;
      end
      else
      begin
        ramping_o <= 1'b1;
        timer     <= tick ? {TW{1'b0}} : timer + {{(TW-1){1'b0}}, 1'b1};
        if (tick)                                                                // (R6) (R7)
        begin
          if (target > dac_code_o)
            dac_code_o <= (gap_up < `DMS_CODE_STEP) ? target : dac_code_o + `DMS_CODE_STEP;
          else
            dac_code_o <= (gap_dn < `DMS_CODE_STEP) ? target : dac_code_o - `DMS_CODE_STEP;
        end
      end
    end
  end

endmodule // dms_margin_slew

`default_nettype wire

/* verification/dms_margin_slew_props.sv */
/*
  Port checker for the margin and slew block: bus pin timing, ramp steps, pulses.
  Assumes it is bound to dms_margin_slew and shares its SLEW_CYCLES.
*/
`timescale 1ns/1ps
`default_nettype none
module dms_chk #(
  parameter SLEW_CYCLES = 8
) (
  // Clock and reset
  input wire       mclk_i,
  input wire       nrst_i,
  // Two-wire bus
  input wire       scl_i,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe_o,
  // Pin and converter side
  input wire       general_input_pin_i,
  input wire [9:0] dac_code_o,
  input wire       dac_en_o,
  input wire       ramping_o,
  input wire       nvm_prog_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  reg [31:0] since;
  reg [9:0]  prev_code;
  // Saturates so a long idle spell cannot wrap round
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      since     <= 32'h00000000;
      prev_code <= 10'h000;
    end
    else
    begin
      prev_code <= dac_code_o;
      if (dac_code_o != prev_code)
        since <= 32'h00000000;
      else if (since != 32'hFFFFFFFF)
        since <= since + 32'h00000001;
    end
  end
  sequence s_moved;
    ramping_o && (dac_code_o != $past(dac_code_o));
  endsequence
  sequence s_one_code;
    (dac_code_o == $past(dac_code_o) + 10'h001) || (dac_code_o + 10'h001 == $past(dac_code_o));
  endsequence
  sequence s_held;
    sda_oe_o [*4];
  endsequence
  property p_step_one; s_moved |-> s_one_code; endproperty
  property p_interval; s_moved |-> since >= SLEW_CYCLES - 1; endproperty
  property p_ramp_end; $fell(ramping_o) |-> $stable(dac_code_o); endproperty
  property p_oe_scl_low; $changed(sda_oe_o) |-> !scl_i; endproperty
  property p_oe_held; $rose(sda_oe_o) |-> s_held; endproperty
  property p_sda_zero; sda_o == 1'b0; endproperty
  property p_prog_pulse; nvm_prog_o |=> !nvm_prog_o; endproperty
  property p_reset_quiet;
    $rose(nrst_i) |-> (dac_code_o == 10'h000) && !dac_en_o && !ramping_o && !nvm_prog_o && !sda_oe_o;
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("ramp step is not one code");
  a_interval: assert property (p_interval)
    else $error("ramp step came before the interval ended");
  a_ramp_end: assert property (p_ramp_end)
    else $error("code moved as ramping ended");
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data line changed while clock high");
  a_oe_held: assert property (p_oe_held)
    else $error("driven bit too short");
  a_sda_zero: assert property (p_sda_zero)
    else $error("data output not zero");
  a_prog_pulse: assert property (p_prog_pulse)
    else $error("programming pulse longer than one cycle");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet after reset");
endmodule // dms_chk

bind dms_margin_slew dms_chk #(.SLEW_CYCLES(SLEW_CYCLES)) u_chk (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .general_input_pin_i(general_input_pin_i), .dac_code_o(dac_code_o), .dac_en_o(dac_en_o),
  .ramping_o(ramping_o), .nvm_prog_o(nvm_prog_o));
`default_nettype wire

/* verification/dms_bus_host.sv */
/*
  Bus host and pin driver model facing the margin and slew block.
  Assumes a pulled-up data wire fed back on sda_i; 8 mclk per bus bit.
*/
`timescale 1ns/1ps
`default_nettype none
module dms_bus_host #(
  parameter [6:0] ADDR = 7'h48
) (
  // Clock and wire level
  input  wire mclk_i,
  input  wire sda_i,
  // Host drivers
  output reg  scl_o,
  output reg  sda_pull_o,
  output reg  general_input_pin_o
);
  integer nak_count;
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
    general_input_pin_o = 1'b0;
    nak_count = 0;
  end
  task wt(input integer n);
    repeat (n) @(negedge mclk_i);
  endtask
  task set_pin(input v);
    general_input_pin_o = v;
  endtask
  // Low 5 cycles, high 3: device answers late in the low phase
  task bit_io(input b, output r);
  begin
    wt(2);
    sda_pull_o = ~b;
    wt(3);
    scl_o = 1'b1;
    wt(3);
    r = sda_i;
    scl_o = 1'b0;
  end
  endtask
  task start;
  begin
    wt(2);
    sda_pull_o = 1'b0;
    wt(2);
    scl_o = 1'b1;
    wt(3);
    sda_pull_o = 1'b1;
    wt(3);
    scl_o = 1'b0;
  end
  endtask
  task stop;
  begin
    wt(2);
    sda_pull_o = 1'b1;
    wt(2);
    scl_o = 1'b1;
    wt(3);
    sda_pull_o = 1'b0;
    wt(3);
  end
  endtask
  task xfer(input [7:0] d, input ack_b, output [7:0] q);
    integer i;
    reg     r;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      bit_io(d[i], r);
      q = {q[6:0], r};
    end
    bit_io(ack_b, r);
    if (ack_b && r)
      nak_count = nak_count + 1;
  end
  endtask
  // Command, then high byte, then low byte; n cuts the segment short
  task write_reg(input [7:0] cmd, input [15:0] w, input integer n);
    reg [7:0] q;
  begin
    start;
    xfer({ADDR, 1'b0}, 1'b1, q);
    if (n > 0) xfer(cmd, 1'b1, q);
    if (n > 1) xfer(w[15:8], 1'b1, q);
    if (n > 2) xfer(w[7:0], 1'b1, q);
    stop;
  end
  endtask
  task read_reg(input [7:0] cmd, input set_ptr, output [15:0] w);
    reg [7:0] q;
  begin
    if (set_ptr)
    begin
      start;
      xfer({ADDR, 1'b0}, 1'b1, q);
      xfer(cmd, 1'b1, q);
    end
    start;
    xfer({ADDR, 1'b1}, 1'b1, q);
    xfer(8'hFF, 1'b0, w[15:8]);
    xfer(8'hFF, 1'b1, w[7:0]);
    // Our own closing NACK is not a device fault
    nak_count = nak_count - 1;
    stop;
  end
  endtask
endmodule // dms_bus_host
`default_nettype wire

/* verification/test_dac_margin_slew_control.sv */
/*
  Self-checking bench for the margin and slew block.
  Assumes the host model drives bus and pin; the step interval is shortened.
*/
`timescale 1ns/1ps
`default_nettype none
module test_dac_margin_slew_control;
  localparam       SLEW = 8;
  localparam [7:0] REV  = 8'h3C; // Arbitrary revision code
  reg         mclk_i;
  reg         nrst_i;
  wire        scl_w;
  wire        sda_w;
  wire        pull_w;
  wire        pin_w;
  wire        sda_o;
  wire        sda_oe_o;
  wire [9:0]  dac_code_o;
  wire        dac_en_o;
  wire        ramping_o;
  wire        nvm_prog_o;
  integer     err_count;
  integer     checks_done;
  integer     prog_count;
  integer     i;
  integer     n;
  reg  [15:0] w;
  reg  [9:0]  lo;
  reg  [9:0]  hi;
  reg  [31:0] ft [0:4];
  reg  [7:0]  op [0:3];
  assign sda_w = ~(sda_oe_o | pull_w);
  dms_margin_slew #(.REVISION(REV), .SLEW_CYCLES(SLEW)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl_w),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .general_input_pin_i(pin_w), .dac_code_o(dac_code_o),
    .dac_en_o(dac_en_o), .ramping_o(ramping_o), .nvm_prog_o(nvm_prog_o));
  dms_bus_host host (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_pull_o(pull_w),
    .general_input_pin_o(pin_w));
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
    if (nvm_prog_o === 1'b1) prog_count = prog_count + 1;
  task check(input [15:0] got, input [15:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  function [15:0] align(input [9:0] c);
    align = {4'h0, c, 2'b00};
  endfunction
  task status(input [15:0] exp);
  begin
    host.read_reg(8'h78, 1'b1, w);
    check(w, exp);
  end
  endtask
  task wait_code(input [9:0] c);
  begin
    n = 0;
    while (dac_code_o !== c && n < 200)
    begin
      @(negedge mclk_i);
      n = n + 1;
    end
  end
  endtask
  task final_report;
  begin
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (80000) @(posedge mclk_i);
    err_count = err_count + 1;
    $display("BAD t=%0t run did not finish", $time);
    final_report;
  end
  initial
  begin
    nrst_i = 1'b0;
    err_count = 0;
    checks_done = 0;
    prog_count = 0;
    w = $urandom(59106);
    ft[0] = {8'h98, 16'h1234, 8'd3};
    ft[1] = {8'h55, 16'h0000, 8'd3};
    ft[2] = {8'h21, 16'h0000, 8'd2};
    ft[3] = {8'h01, 16'h1200, 8'd3};
    ft[4] = {8'hD1, 16'h0003, 8'd3};
    op[0] = 8'hA4;
    op[1] = 8'h94;
    op[2] = 8'h00;
    op[3] = 8'h80;
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    nrst_i = 1'b1;
    host.wt(4);
    host.read_reg(8'h00, 1'b0, w);
    check(w, 16'h0000);
    status(16'h0200);
    w = $urandom;
    host.write_reg(8'h78, w & 16'hFDFF, 3);
    status(16'h0200);
    host.write_reg(8'h78, 16'h0000, 3);
    status(16'h0200);
    w = $urandom;
    host.write_reg(8'h78, w | 16'h0200, 3);
    status(16'h0000);
    host.read_reg(8'h98, 1'b1, w);
    check(w, {REV, 8'h00});
    host.read_reg(8'h25, 1'b1, w);
    check(w, 16'h0000);
    for (i = 0; i < 5; i = i + 1)
    begin
      host.write_reg(ft[i][31:24], ft[i][23:8], ft[i][7:0]);
      status(16'h0200);
      host.write_reg(8'h78, $urandom | 16'h0200, 3);
      status(16'h0000);
    end
    $display("test faults done");
    hi = $urandom;
    lo = $urandom;
    host.write_reg(8'hD1, $urandom & 16'hFFF0, 3);
    host.write_reg(8'h25, align(hi), 3);
    host.write_reg(8'h26, align(lo), 3);
    host.read_reg(8'h25, 1'b1, w);
    check(w, align(hi));
    w = $urandom;
    host.write_reg(8'h21, align(w[9:0]), 3);
    host.wt(2);
    check(dac_code_o, w[9:0]);
    for (i = 0; i < 4; i = i + 1)
    begin
      host.write_reg(8'h01, {op[i], 8'h00}, 3);
      host.wt(4);
      check(dac_en_o, op[i] != 8'h00);
      if (i < 2) check(dac_code_o, i == 0 ? hi : lo);
    end
    $display("test operations done");
    lo = $urandom % 1000;
    hi = lo + 10'h003;
    host.write_reg(8'h25, align(hi), 3);
    host.write_reg(8'h26, align(lo), 3);
    host.write_reg(8'h21, align(lo), 3);
    host.write_reg(8'hD1, 16'h0004, 3);
    host.write_reg(8'hD2, 16'h1000, 3);
    host.write_reg(8'hD3, 16'h0408, 3);
    check(prog_count, 0);
    host.set_pin(1'b1);
    wait_code(hi);
    check(n >= 3 * SLEW && n <= 3 * SLEW + 6, 1'b1);
    host.set_pin(1'b0);
    wait_code(hi - 10'h001);
    host.set_pin(1'b1);
    n = 0;
    while (dac_code_o === hi - 10'h001 && n < 40)
    begin
      @(negedge mclk_i);
      n = n + 1;
    end
    check(dac_code_o, hi);
    check(n >= SLEW - 1 && n <= SLEW + 1, 1'b1);
    host.write_reg(8'hD3, 16'h0418, 3);
    check(prog_count, 1);
    host.read_reg(8'hD3, 1'b1, w);
    check(w, 16'h0408);
    host.set_pin(1'b0);
    wait_code(lo);
    check(dac_code_o, lo);
    host.write_reg(8'hD3, $urandom & 16'hFFE7, 3);
    host.set_pin(1'b1);
    host.wt(40);
    check(dac_code_o, lo);
    check(host.nak_count, 0);
    $display("test ramp done");
    final_report;
  end
endmodule // test_dac_margin_slew_control
`default_nettype wire
